// >>> inc/prw_pkg.sv
// Types shared by the register window block and its users.
// Assumes prw_regs.svh is included by files that need the constants.
package prw_pkg;
    // Request from the execution and bus interface units
    typedef struct packed {
        logic valid;
        logic is_mem;
        logic write;
        logic word;
        logic [19:0] addr;
        logic [15:0] wdata;
    } prw_req_t;

    // Mirror of the access on the external pins
    typedef struct packed {
        logic valid;
        logic is_mem;
        logic write;
        logic byte8;
        logic [19:0] addr;
        logic [15:0] wdata;
    } prw_ext_t;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ACC = 6'h02,
        ST_WAIT = 6'h04,
        ST_SEC = 6'h08,
        ST_EXTW = 6'h10,
        ST_FIN = 6'h20
    } prw_state_t;
endpackage : prw_pkg

// >>> inc/prw_regs.svh
// Offsets, field positions and reset values of the register window block.
// Included by the package user files; definitions only.
`ifndef PRW_REGS_SVH
`define PRW_REGS_SVH
// APB register byte addresses
`define PRW_APB_CTRL 12'h000
`define PRW_APB_STAT 12'h004
`define PRW_APB_RELOC 12'h008
// Control register fields
`define PRW_CTRL_BUS8 0
`define PRW_CTRL_CASCADE 1
// Relocation register layout and reset value
`define PRW_RELOC_RESET 16'h00ff
`define PRW_RELOC_MEM 12
`define PRW_RELOC_ET 14
`define PRW_RELOC_MASK 16'h5fff
// Fixed offsets inside the window; coprocessor I/O page and its start offset
`define PRW_OFF_RELOC 8'ha8
`define PRW_OFF_TMR_LO 8'h30
`define PRW_OFF_TMR_HI 8'h47
`define PRW_COP_BASE 8'h00
`define PRW_COP_LO 8'hf8
// One bit per window word: set where a register is assigned
`define PRW_ASSIGNED 128'h00000000_5f1fffff_3f3fff0b_ff00fffe
`endif

// >>> rtl/prw_mem.sv
// Word store behind the peripheral bus, 128 words of 16 bits.
// Assumes one access per cycle; read data come from a register.
`timescale 1ns/10ps
module prw_mem (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Write port
    input wire logic we,
    input wire logic [6:0] waddr,
    input wire logic [15:0] wdata,
    // Read port
    input wire logic re,
    input wire logic [6:0] raddr,
    output logic [15:0] rdata
);
    logic [15:0] mem [0:127];

    always_ff @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata <= 16'h0000;
        end else if (re) begin
            rdata <= mem[raddr];
        end
    end
endmodule : prw_mem

// >>> rtl/prw_sync.sv
// Three-stage synchroniser for a pin level.
// Assumes the input is asynchronous to pclk.
`timescale 1ns/10ps
module prw_sync (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pin and clean level
    input wire logic pin,
    output logic level
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Level moves only once two late stages agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level <= 1'b0;
        end else if (s2 == s3) begin
            level <= s3;
        end
    end
endmodule : prw_sync

// >>> rtl/prw_window.sv
// Access and relocation logic of the peripheral register window.
// Assumes the core presents one request at a time and waits for ready.
`timescale 1ns/10ps
`include "prw_regs.svh"

module prw_window (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core request and answer
    input wire prw_pkg::prw_req_t cpu_req,
    output logic cpu_hit,
    output logic cpu_busy,
    output logic cpu_ready,
    output logic [15:0] cpu_rdata,
    output logic cpu_rdata_hi,
    // External bus mirror
    input wire logic ext_ready_pin,
    output prw_pkg::prw_ext_t ext_cyc,
    output logic ext_ready_ignore,
    // Coprocessor interface
    output logic cop_sel,
    output logic esc_trap
);
    prw_pkg::prw_state_t st;
    prw_pkg::prw_state_t next_st;
    prw_pkg::prw_req_t req;
    logic [15:0] reloc;
    logic bus8;
    logic cascade;
    logic ext_ready_s;
    logic [15:0] mem_q;
    logic mem_we;
    logic [15:0] store_word;
    logic [7:0] off;
    logic take;
    logic sec_hit;
    logic [19:0] sec_addr;
    logic apb_wr;
    logic [15:0] rd_word;

    // One bit per window word, indexable copy of the assigned map
    localparam logic [127:0] assigned_map = `PRW_ASSIGNED;
    localparam logic [6:0] reloc_word = 7'(`PRW_OFF_RELOC >> 1);

    function automatic logic win_hit(input logic [15:0] r,
                                     input logic is_mem,
                                     input logic [19:0] a);
        logic io_ok;
        logic mem_ok;
        io_ok = !is_mem && !r[`PRW_RELOC_MEM]
            && (a[15:8] == r[7:0]);
        mem_ok = is_mem && r[`PRW_RELOC_MEM]
            && (a[19:8] == r[11:0]);
        return io_ok || mem_ok;
    endfunction : win_hit

    function automatic logic is_timer(input logic [7:0] o);
        return (o >= `PRW_OFF_TMR_LO) && (o <= `PRW_OFF_TMR_HI);
    endfunction : is_timer

    assign off = req.addr[7:0];
    assign take = (st == prw_pkg::ST_IDLE) && cpu_req.valid
        && cpu_hit;
    assign sec_addr = req.addr + 20'h00001;
    assign sec_hit = win_hit(reloc, req.is_mem, sec_addr);

    // Core-facing decode
    always_comb begin
        cpu_hit = win_hit(reloc, cpu_req.is_mem, cpu_req.addr);
    end

    assign cpu_busy = (st != prw_pkg::ST_IDLE);
    assign cpu_ready = (st == prw_pkg::ST_FIN);

    // Window claims the coprocessor range before the coprocessor does
    always_comb begin
        cop_sel = cpu_req.valid && !cpu_req.is_mem
            && (cpu_req.addr[15:8] == `PRW_COP_BASE)
            && (cpu_req.addr[7:0] >= `PRW_COP_LO)
            && !cpu_hit;
    end

    assign esc_trap = reloc[`PRW_RELOC_ET] || bus8;

    // External ready is marked ignored outside idle and the wait on it, and always when cascaded at I/O page 00
    always_comb begin
        ext_ready_ignore = (st != prw_pkg::ST_IDLE)
            && (st != prw_pkg::ST_EXTW);
        if (cascade && !reloc[`PRW_RELOC_MEM]
            && (reloc[7:0] == 8'h00)) begin
            ext_ready_ignore = 1'b1;
        end
    end

    prw_sync u_rdy_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin(ext_ready_pin),
        .level(ext_ready_s)
    );

    // Sequencer
    always_comb begin
        next_st = st;
        case (st)
            prw_pkg::ST_IDLE: begin
                if (take) begin
                    next_st = prw_pkg::ST_ACC;
                end
            end
            prw_pkg::ST_ACC: begin
                if (is_timer(off)) begin
                    next_st = prw_pkg::ST_WAIT;
                end else if (bus8 && req.word) begin
                    next_st = prw_pkg::ST_SEC;
                end else begin
                    next_st = prw_pkg::ST_FIN;
                end
            end
            prw_pkg::ST_WAIT: begin
                if (bus8 && req.word) begin
                    next_st = prw_pkg::ST_SEC;
                end else begin
                    next_st = prw_pkg::ST_FIN;
                end
            end
            prw_pkg::ST_SEC: begin
                if (sec_hit) begin
                    next_st = prw_pkg::ST_FIN;
                end else begin
                    next_st = prw_pkg::ST_EXTW;
                end
            end
            prw_pkg::ST_EXTW: begin
                if (ext_ready_s) begin
                    next_st = prw_pkg::ST_FIN;
                end
            end
            prw_pkg::ST_FIN: begin
                next_st = prw_pkg::ST_IDLE;
            end
            default: begin
                next_st = prw_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= prw_pkg::ST_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // Captured request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req <= '0;
        end else if (take) begin
            req <= cpu_req;
        end
    end

    // External cycle mirror, second cycle on the eight-bit bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_cyc <= '0;
        end else if (take) begin
            ext_cyc.valid <= 1'b1;
            ext_cyc.is_mem <= cpu_req.is_mem;
            ext_cyc.write <= cpu_req.write;
            ext_cyc.byte8 <= bus8;
            ext_cyc.addr <= cpu_req.addr;
            ext_cyc.wdata <= cpu_req.wdata;
        end else if (next_st == prw_pkg::ST_SEC) begin
            ext_cyc.valid <= 1'b1;
            ext_cyc.addr <= sec_addr;
            ext_cyc.wdata <= {8'h00, req.wdata[15:8]};
        end else begin
            ext_cyc.valid <= 1'b0;
        end
    end

    // Full word always stored; odd target swaps the bytes
    always_comb begin
        if (req.addr[0]) begin
            store_word = {req.wdata[7:0], req.wdata[15:8]};
        end else begin
            store_word = req.wdata;
        end
    end

    assign mem_we = (st == prw_pkg::ST_ACC) && req.write
        && assigned_map[off[7:1]] && (off != `PRW_OFF_RELOC);

    prw_mem u_mem (
        .pclk(pclk),
        .presetn(presetn),
        .we(mem_we),
        .waddr(off[7:1]),
        .wdata(store_word),
        .re(take),
        .raddr(cpu_req.addr[7:1]),
        .rdata(mem_q)
    );

    // Relocation register, written once per access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reloc <= `PRW_RELOC_RESET;
        end else if ((st == prw_pkg::ST_ACC) && req.write
                     && (off == `PRW_OFF_RELOC)) begin
            reloc <= store_word & `PRW_RELOC_MASK;
        end
    end

    // Relocation word comes from its own flops, the rest from the store
    assign rd_word = (off[7:1] == reloc_word) ? reloc : mem_q;

    // Read answer; unassigned words return whatever the store holds
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_rdata <= 16'h0000;
            cpu_rdata_hi <= 1'b0;
        end else if (st == prw_pkg::ST_ACC) begin
            if (req.word && off[0]) begin
                cpu_rdata <= {rd_word[7:0], rd_word[15:8]};
            end else if (req.word) begin
                cpu_rdata <= rd_word;
            end else if (off[0]) begin
                cpu_rdata <= {8'h00, rd_word[15:8]};
            end else begin
                cpu_rdata <= {8'h00, rd_word[7:0]};
            end
            cpu_rdata_hi <= req.word;
        end
    end

    // APB slave: zero wait, error on unmapped address
    assign pready = 1'b1;
    assign apb_wr = psel && penable && pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus8 <= 1'b0;
            cascade <= 1'b0;
        end else if (apb_wr && (paddr == `PRW_APB_CTRL)) begin
            bus8 <= pwdata[`PRW_CTRL_BUS8];
            cascade <= pwdata[`PRW_CTRL_CASCADE];
        end
    end

    always_comb begin
        prdata = 32'h0000_0000;
        pslverr = 1'b0;
        case (paddr)
            `PRW_APB_CTRL: begin
                prdata[`PRW_CTRL_BUS8] = bus8;
                prdata[`PRW_CTRL_CASCADE] = cascade;
            end
            `PRW_APB_STAT: begin
                prdata[5:0] = st;
                prdata[8] = ext_ready_ignore;
                prdata[9] = esc_trap;
            end
            `PRW_APB_RELOC: begin
                prdata[15:0] = reloc;
            end
            default: begin
                pslverr = psel && penable;
            end
        endcase
    end

    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_zero_wait: assert property (
        (st == prw_pkg::ST_ACC) && !is_timer(off) && !(bus8 && req.word)
        |=> cpu_ready)
        else $error("zero wait access not done in one cycle");

    chk_timer_wait: assert property (
        (st == prw_pkg::ST_ACC) && is_timer(off) && !(bus8 && req.word)
        |=> !cpu_ready ##1 cpu_ready)
        else $error("timer access lacks exactly one wait");

    chk_ext_mirror: assert property (
        take |=> ext_cyc.valid && (ext_cyc.addr == $past(cpu_req.addr)))
        else $error("window access not mirrored externally");

    chk_unassigned_store: assert property (
        mem_we |-> assigned_map[off[7:1]])
        else $error("write stored to unassigned word");

    chk_reloc_cause: assert property (
        $changed(reloc) |-> $past(st == prw_pkg::ST_ACC && req.write
                                  && off == `PRW_OFF_RELOC))
        else $error("relocation changed without a write");

    chk_odd_word_read: assert property (
        (st == prw_pkg::ST_ACC) && req.word && off[0]
        && (off != `PRW_OFF_RELOC + 8'h01)
        |=> cpu_rdata == {$past(mem_q[7:0]), $past(mem_q[15:8])})
        else $error("odd word read not swapped");

    chk_ready_internal: assert property (
        (st == prw_pkg::ST_ACC) |-> ext_ready_ignore [*1] ##1 1'b1)
        else $error("external ready not ignored in window");

    chk_esc_trap_bus8: assert property (
        bus8 |-> esc_trap)
        else $error("eight-bit variant must trap escape");

    chk_bus8_second: assert property (
        (st == prw_pkg::ST_ACC) && bus8 && req.word && !is_timer(off)
        |=> ext_cyc.valid ##1 !ext_cyc.valid)
        else $error("second external cycle missing");

    chk_hit_taken: assert property (
        (st == prw_pkg::ST_IDLE) && cpu_req.valid && cpu_hit
        |=> st == prw_pkg::ST_ACC)
        else $error("window hit not taken");

    cov_timer: cover property (
        (st == prw_pkg::ST_WAIT) ##1 cpu_ready);
    cov_second: cover property (
        (st == prw_pkg::ST_SEC) ##1 (st == prw_pkg::ST_FIN));
    cov_extw: cover property (
        (st == prw_pkg::ST_EXTW) ##[1:20] cpu_ready);
    cov_reloc: cover property ($changed(reloc));
endmodule : prw_window

// >>> tb/prw_cpu_model.sv
// Core side model: execution and bus interface unit requests.
// Assumes the window ends each access it claims with cpu_ready.
`timescale 1ns/10ps
module prw_cpu_model (
    // Clock
    input wire logic pclk,
    // Request and answer
    output prw_pkg::prw_req_t cpu_req,
    input wire logic cpu_hit,
    input wire logic cop_sel,
    input wire logic cpu_ready,
    input wire logic [15:0] cpu_rdata,
    input wire logic cpu_rdata_hi,
    // External mirror
    input wire prw_pkg::prw_ext_t ext_cyc
);
    logic [15:0] rd;
    logic hi;
    logic hit;
    logic cop;
    logic eb;
    logic [19:0] ea;
    int lat;
    int np;

    initial cpu_req = '0;

    // Request held until internal ready; a miss is dropped at once
    task automatic access(input logic m, w, wd, input logic [19:0] a,
                          input logic [15:0] d);
        @(posedge pclk);
        cpu_req <= '{1'b1, m, w, wd, a, d};
        np = 0;
        ea = '0;
        eb = 1'b0;
        @(posedge pclk);
        lat = 1;
        hit = cpu_hit;
        cop = cop_sel;
        while (hit === 1'b1 && cpu_ready !== 1'b1 && lat < 200) begin
            @(posedge pclk);
            lat++;
            if (ext_cyc.valid === 1'b1) begin
                if (np == 0) begin
                    ea = ext_cyc.addr;
                    eb = ext_cyc.byte8;
                end
                np++;
            end
        end
        rd = cpu_rdata;
        hi = cpu_rdata_hi;
        cpu_req.valid <= 1'b0;
        cpu_req.wdata <= ~d;
    endtask : access
endmodule : prw_cpu_model

// >>> tb/prw_window_tb.sv
// Self-checking bench for the peripheral register window.
// Assumes prw_cpu_model on the core side; APB master lives here.
`timescale 1ns/10ps
module prw_window_tb;
    localparam logic IO = 1'b0, MEM = 1'b1, RD = 1'b0, WR = 1'b1;
    localparam logic BY = 1'b0, WD = 1'b1;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rv;
    logic pready, pslverr, ev, cpu_hit, cpu_busy, cpu_ready, cpu_rdata_hi;
    logic ext_rdy = 1'b0;
    logic ext_ign, cop_sel, esc_trap;
    logic [15:0] cpu_rdata;
    prw_pkg::prw_req_t cpu_req;
    prw_pkg::prw_ext_t ext_cyc;
    int miscompares = 0;
    int comparisons = 0;

    prw_window u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpu_req(cpu_req), .cpu_hit(cpu_hit), .cpu_busy(cpu_busy),
        .cpu_ready(cpu_ready), .cpu_rdata(cpu_rdata),
        .cpu_rdata_hi(cpu_rdata_hi), .ext_ready_pin(ext_rdy),
        .ext_cyc(ext_cyc), .ext_ready_ignore(ext_ign), .cop_sel(cop_sel),
        .esc_trap(esc_trap));

    prw_cpu_model u_cpu (.pclk(pclk), .cpu_req(cpu_req), .cpu_hit(cpu_hit),
        .cop_sel(cop_sel), .cpu_ready(cpu_ready), .cpu_rdata(cpu_rdata),
        .cpu_rdata_hi(cpu_rdata_hi), .ext_cyc(ext_cyc));

    always #2 pclk = ~pclk;

    task automatic chk(input logic [31:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_ne(input logic [31:0] got, bad);
        comparisons++;
        if (got === bad) begin
            miscompares++;
            $display("BAD %0t stored value read back %h", $time, got);
        end
    endtask : chk_ne

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic acc(input logic m, w, wd, input logic [19:0] a,
                       input logic [15:0] d);
        u_cpu.access(m, w, wd, a, d);
    endtask : acc

    task automatic report_and_stop;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        report_and_stop();
    end

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h008, 32'h0);
        chk(rv, 32'h0000_00ff);
        apb(1'b1, 12'h008, 32'h0000_1234);
        apb(1'b0, 12'h008, 32'h0);
        chk(rv, 32'h0000_00ff);
        apb(1'b0, 12'h00c, 32'h0);
        chk(ev, 1'b1);
        chk(rv, 32'h0000_0000);
        apb(1'b1, 12'h000, 32'h0000_0002);
        chk({esc_trap, ext_ign}, 2'b00);
        acc(IO, RD, WD, 20'h000f8, 16'h0);
        chk({u_cpu.hit, u_cpu.cop}, 2'b01);
        $display("reset and map test done");
        acc(IO, WR, WD, 20'h0ff02, 16'h1234);
        chk(u_cpu.lat, 3);
        chk(u_cpu.np, 1);
        chk(u_cpu.ea, 20'h0ff02);
        acc(IO, RD, WD, 20'h0ff02, 16'h0);
        chk({u_cpu.hi, u_cpu.rd}, 17'h1_1234);
        acc(IO, WR, WD, 20'h0ff30, 16'h0);
        chk(u_cpu.lat, 4);
        acc(IO, RD, WD, 20'h0ff46, 16'h0);
        chk(u_cpu.lat, 4);
        $display("timing test done");
        acc(IO, WR, WD, 20'h0ff03, 16'habcd);
        acc(IO, RD, WD, 20'h0ff02, 16'h0);
        chk(u_cpu.rd, 16'hcdab);
        acc(IO, RD, WD, 20'h0ff03, 16'h0);
        chk(u_cpu.rd, 16'habcd);
        acc(IO, RD, BY, 20'h0ff03, 16'h0);
        chk({u_cpu.hi, u_cpu.rd[7:0]}, 9'h0cd);
        acc(IO, WR, BY, 20'h0ff04, 16'h5678);
        acc(IO, RD, WD, 20'h0ff04, 16'h0);
        chk(u_cpu.rd, 16'h5678);
        acc(IO, WR, WD, 20'h0ff20, 16'h1111);
        chk(u_cpu.lat, 3);
        acc(IO, RD, WD, 20'h0ff20, 16'h0);
        chk_ne(u_cpu.rd, 16'h1111);
        acc(IO, WR, WD, 20'h0ff20, 16'h0000);
        $display("alignment test done");
        acc(IO, WR, BY, 20'h0ffa8, 16'h1100);
        apb(1'b0, 12'h008, 32'h0);
        chk(rv, 32'h0000_1100);
        acc(MEM, RD, WD, 20'h100a8, 16'h0);
        chk(u_cpu.rd, 16'h1100);
        acc(IO, RD, WD, 20'h0ff02, 16'h0);
        chk(u_cpu.hit, 1'b0);
        chk(ext_ign, 1'b0);
        acc(MEM, WR, BY, 20'h100a8, 16'h4000);
        chk(ext_ign, 1'b1);
        chk(esc_trap, 1'b1);
        acc(IO, RD, WD, 20'h000f8, 16'h0);
        chk({u_cpu.hit, u_cpu.cop}, 2'b10);
        acc(IO, WR, BY, 20'h000a8, 16'h00ff);
        chk(esc_trap, 1'b0);
        apb(1'b1, 12'h000, 32'h0000_0003);
        @(negedge pclk);
        chk(esc_trap, 1'b1);
        acc(IO, WR, BY, 20'h0ffa8, 16'h4000);
        chk(u_cpu.np, 1);
        chk(u_cpu.eb, 1'b1);
        $display("relocation test done");
        acc(IO, RD, WD, 20'h00002, 16'h0);
        chk(u_cpu.lat, 4);
        chk(u_cpu.np, 2);
        chk(u_cpu.rd, 16'hcdab);
        fork
            acc(IO, WR, WD, 20'h000a8, 16'h00ff);
            begin
                repeat (12) @(posedge pclk);
                ext_rdy <= 1'b1;
            end
        join
        chk(u_cpu.lat > 12, 1'b1);
        ext_rdy <= 1'b0;
        apb(1'b0, 12'h008, 32'h0);
        chk(rv, 32'h0000_00ff);
        acc(IO, WR, BY, 20'h0ff04, 16'h9abc);
        chk(u_cpu.np, 1);
        acc(IO, RD, WD, 20'h0ff04, 16'h0);
        chk(u_cpu.rd, 16'h9abc);
        $display("narrow bus test done");
        report_and_stop();
    end
endmodule : prw_window_tb
